// ==== core/rwt_top.sv ====
`include "rwt_regs.svh"
`default_nettype none
module rwt_top
  import rwt_pkg::*;
(
  input wire logic CLOCK_I,
  input wire logic RESET_N_I,
  input wire logic [`RWT_AW-1:0] ADDR_I,
  input wire logic [`RWT_DW-1:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [`RWT_DW-1:0] RDATA_O,
  input wire logic [2:0] CLK_SRC_I,
  input wire logic EVENT_A_I,
  input wire logic EVENT_B_I,
  output logic WAVE_OUT_PRIMARY_A_O,
  output logic WAVE_OUT_PRIMARY_B_O,
  output logic WAVE_OUT_MIRROR_C_O,
  output logic WAVE_OUT_MIRROR_D_O,
  output logic CMP_EVENT_O,
  output logic OVF_EVENT_O
);
  localparam int CW = `RWT_CW;

  logic [7:0] control_first_q;
  logic [5:0] control_second_q;
  logic [3:0] delay_control_q;
  logic [7:0] blank_len_q;
  logic [6:0] evctrl_q [2];
  logic [CW-1:0] cmp_q [4];
  logic [CW-1:0] cap_q [2];
  logic [1:0] sw_cap_q;
  logic en_req_q;
  logic en_s1_q, en_s2_q;
  logic fault_q;
  logic [`RWT_DW-1:0] rdata_q;
  logic wr_static;

  wire logic core_en = en_s2_q;
  wire logic enable_ready_flag = (en_req_q == en_s2_q);
  wire logic [1:0] src_sel = control_first_q[`RWT_CF_SRC_LO +: 2];
  wire logic [1:0] syncp_sel = control_first_q[`RWT_CF_SYNCP_LO +: 2];
  wire logic [1:0] cntp_sel = control_first_q[`RWT_CF_CNTP_LO +: 2];
  wire rwt_wgmode_t wg = rwt_wgmode_t'(control_second_q[`RWT_CS_WG_LO +: 2]);
  wire logic [1:0] dlyp_sel = delay_control_q[`RWT_DC_DLYP_LO +: 2];
  wire logic [1:0] blank_sel = delay_control_q[`RWT_DC_BLANK_LO +: 2];
  wire logic [CW-1:0] a_set = cmp_q[0];
  wire logic [CW-1:0] a_clr = cmp_q[1];
  wire logic [CW-1:0] b_set = cmp_q[2];
  wire logic [CW-1:0] b_clr = cmp_q[3];

  // static settings only while stopped, enable request blocks them too
  assign wr_static = WR_I && !en_req_q && !core_en;

  always_ff @(posedge CLOCK_I) begin
    if (!RESET_N_I) begin
      control_first_q <= 8'h00;
      control_second_q <= 6'h00;
      evctrl_q[0] <= 7'h00;
      evctrl_q[1] <= 7'h00;
    end else if (wr_static) begin
      case (ADDR_I)
        `RWT_CONTROL_FIRST: control_first_q[7:1] <= WDATA_I[7:1];
        `RWT_CONTROL_SECOND: control_second_q <= WDATA_I[5:0];
        `RWT_EVCTRL_A: evctrl_q[0] <= WDATA_I[6:0];
        `RWT_EVCTRL_B: evctrl_q[1] <= WDATA_I[6:0];
        default: ;
      endcase
    end
  end

  // buffered settings may change while running
  always_ff @(posedge CLOCK_I) begin
    if (!RESET_N_I) begin
      delay_control_q <= 4'h0;
      blank_len_q <= 8'h00;
      for (int i = 0; i < 4; i++) begin
        cmp_q[i] <= 12'h000;
      end
    end else if (WR_I) begin
      case (ADDR_I)
        `RWT_DELAY_CONTROL: delay_control_q <= WDATA_I[3:0];
        `RWT_BLANK_LEN: blank_len_q <= WDATA_I[7:0];
        `RWT_A_SET: cmp_q[0] <= WDATA_I[CW-1:0];
        `RWT_A_CLR: cmp_q[1] <= WDATA_I[CW-1:0];
        `RWT_B_SET: cmp_q[2] <= WDATA_I[CW-1:0];
        `RWT_B_CLR: cmp_q[3] <= WDATA_I[CW-1:0];
        default: ;
      endcase
    end
  end

  // enable taken only when the previous request has crossed
  always_ff @(posedge CLOCK_I) begin
    if (!RESET_N_I) begin
      en_req_q <= 1'b0;
    end else if (WR_I && ADDR_I == `RWT_CONTROL_FIRST &&
                 enable_ready_flag) begin
      en_req_q <= WDATA_I[`RWT_CF_EN];
    end
  end

  // dedicated synchroniser path for the enable handshake
  always_ff @(posedge CLOCK_I) begin
    if (!RESET_N_I) begin
      en_s1_q <= 1'b0;
      en_s2_q <= 1'b0;
    end else begin
      en_s1_q <= en_req_q;
      en_s2_q <= en_s1_q;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RESET_N_I) begin
      sw_cap_q <= 2'b00;
    end else begin
      sw_cap_q <= (WR_I && ADDR_I == `RWT_COMMAND) ?
                  WDATA_I[`RWT_CMD_CAPA +: 2] : 2'b00;
    end
  end

  // clock sources: 0 is the system clock, 1..3 are sampled pins
  logic [2:0] src_s1_q, src_s2_q, src_s3_q;
  logic [3:0] src_tick;
  assign src_tick[0] = 1'b1;
  genvar gs;
  generate
    for (gs = 0; gs < 3; gs++) begin : g_src
      always_ff @(posedge CLOCK_I) begin
        if (!RESET_N_I) begin
          src_s1_q[gs] <= 1'b0;
          src_s2_q[gs] <= 1'b0;
          src_s3_q[gs] <= 1'b0;
        end else begin
          src_s1_q[gs] <= CLK_SRC_I[gs];
          src_s2_q[gs] <= src_s1_q[gs];
          src_s3_q[gs] <= src_s2_q[gs];
        end
      end
      assign src_tick[gs+1] = src_s2_q[gs] && !src_s3_q[gs];
    end
  endgenerate
  wire logic base_tick = src_tick[src_sel];

  // cascaded prescalers: total division is the product of both
  logic [2:0] syncp_cnt_q;
  logic [5:0] cntp_cnt_q;
  logic [5:0] dlyp_cnt_q;
  wire logic [2:0] syncp_max = 3'((4'h1 << syncp_sel) - 4'h1);
  wire logic [5:0] cntp_max = 6'((7'h01 << {cntp_sel, 1'b0}) - 7'h01);
  wire logic [5:0] dlyp_max = 6'((7'h01 << {dlyp_sel, 1'b0}) - 7'h01);
  wire logic sync_tick = base_tick && syncp_cnt_q == syncp_max;
  wire logic tick = sync_tick && cntp_cnt_q == cntp_max;
  wire logic dly_tick = base_tick && dlyp_cnt_q == dlyp_max;

  always_ff @(posedge CLOCK_I) begin
    if (!RESET_N_I || !core_en) begin
      syncp_cnt_q <= 3'h0;
    end else if (base_tick) begin
      syncp_cnt_q <= sync_tick ? 3'h0 : syncp_cnt_q + 3'h1;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RESET_N_I || !core_en) begin
      cntp_cnt_q <= 6'h00;
    end else if (sync_tick) begin
      cntp_cnt_q <= tick ? 6'h00 : cntp_cnt_q + 6'h01;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RESET_N_I || !core_en) begin
      dlyp_cnt_q <= 6'h00;
    end else if (base_tick) begin
      dlyp_cnt_q <= dly_tick ? 6'h00 : dlyp_cnt_q + 6'h01;
    end
  end

  // event inputs: sync, filter, blanking, edge
  logic [1:0] ev_raw;
  logic [1:0] ev_s1_q, ev_s2_q, ev_filt_q, ev_last_q;
  logic [2:0] filt_cnt_q [2];
  logic [7:0] blank_cnt_q;
  logic blank_trig;
  logic [1:0] ev_level, ev_edge, ev_pol;
  assign ev_raw = {EVENT_B_I, EVENT_A_I};
  wire logic blanking = blank_cnt_q != 8'h00;
  genvar ge;
  generate
    for (ge = 0; ge < 2; ge++) begin : g_ev
      always_ff @(posedge CLOCK_I) begin
        if (!RESET_N_I) begin
          ev_s1_q[ge] <= 1'b0;
          ev_s2_q[ge] <= 1'b0;
        end else begin
          ev_s1_q[ge] <= ev_raw[ge];
          ev_s2_q[ge] <= ev_s1_q[ge];
        end
      end
      // invert only after the synchroniser, the pin meets a bare flop
      assign ev_pol[ge] = ev_s2_q[ge] ^ evctrl_q[ge][`RWT_EV_INV];
      // filter: new level must persist a few samples
      always_ff @(posedge CLOCK_I) begin
        if (!RESET_N_I) begin
          filt_cnt_q[ge] <= 3'h0;
          ev_filt_q[ge] <= 1'b0;
        end else if (!evctrl_q[ge][`RWT_EV_FILT]) begin
          filt_cnt_q[ge] <= 3'h0;
          ev_filt_q[ge] <= ev_pol[ge];
        end else if (ev_pol[ge] == ev_filt_q[ge]) begin
          filt_cnt_q[ge] <= 3'h0;
        end else if (filt_cnt_q[ge] == `RWT_FILTER_LEN) begin
          filt_cnt_q[ge] <= 3'h0;
          ev_filt_q[ge] <= ev_pol[ge];
        end else begin
          filt_cnt_q[ge] <= filt_cnt_q[ge] + 3'h1;
        end
      end
      always_ff @(posedge CLOCK_I) begin
        if (!RESET_N_I) begin
          ev_last_q[ge] <= 1'b0;
        end else begin
          ev_last_q[ge] <= ev_level[ge];
        end
      end
      assign ev_level[ge] = ev_filt_q[ge] && !blanking;
      assign ev_edge[ge] = ev_level[ge] && !ev_last_q[ge];
    end
  endgenerate

  // mode table: {latch, restart, skip, halt, off}
  function automatic logic [4:0] mode_act(input logic [3:0] m);
    case (m)
      4'h1: mode_act = 5'b00100;
      4'h2: mode_act = 5'b01000;
      4'h3: mode_act = 5'b00010;
      4'h4: mode_act = 5'b00001;
      4'h5: mode_act = 5'b00011;
      4'h6: mode_act = 5'b01001;
      4'h7: mode_act = 5'b10000;
      4'h8: mode_act = 5'b10010;
      4'h9: mode_act = 5'b00101;
      default: mode_act = 5'b00000;
    endcase
  endfunction

  logic [4:0] act [2];
  assign act[0] = mode_act(evctrl_q[0][`RWT_EV_MODE_LO +: 4]);
  assign act[1] = mode_act(evctrl_q[1][`RWT_EV_MODE_LO +: 4]);
  wire logic [1:0] ev_on = ev_level & {act[1][0], act[0][0]};
  wire logic out_off = |ev_on || fault_q;
  wire logic halt = |(ev_level & {act[1][1], act[0][1]});
  wire logic skip_ev = |(ev_edge & {act[1][2], act[0][2]});
  wire logic restart_ev = |(ev_edge & {act[1][3], act[0][3]});
  wire logic latch_ev = |(ev_edge & {act[1][4], act[0][4]});

  // fault latch: set wins over the software clear
  always_ff @(posedge CLOCK_I) begin
    if (!RESET_N_I) begin
      fault_q <= 1'b0;
    end else if (latch_ev) begin
      fault_q <= 1'b1;
    end else if (WR_I && ADDR_I == `RWT_COMMAND &&
                 WDATA_I[`RWT_CMD_FCLR]) begin
      fault_q <= 1'b0;
    end
  end

  // counter core
  logic [CW-1:0] cnt_q;
  rwt_state_t phase_q;
  logic down_q;
  logic [CW-1:0] top;
  always_comb begin
    case (wg)
      RWT_TWO: top = (phase_q == RWT_DTA) ? a_clr : b_clr;
      RWT_FOUR: top = cmp_q[phase_q];
      default: top = b_clr;
    endcase
  end
  wire logic at_top = cnt_q == top;
  wire logic run = core_en && tick && !halt;
  wire logic wrap = run && wg != RWT_DUAL && at_top;
  logic cyc_end;
  always_comb begin
    case (wg)
      RWT_ONE: cyc_end = wrap;
      RWT_TWO: cyc_end = wrap && phase_q == RWT_DTB;
      RWT_FOUR: cyc_end = wrap && phase_q == RWT_OTB;
      RWT_DUAL: cyc_end = run && down_q && cnt_q == 12'h000;
      default: cyc_end = 1'b0;
    endcase
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RESET_N_I || !core_en || restart_ev) begin
      cnt_q <= 12'h000;
      phase_q <= RWT_DTA;
      down_q <= 1'b0;
    end else if (skip_ev) begin
      cnt_q <= 12'h000;
      phase_q <= (wg == RWT_TWO) ?
                 ((phase_q == RWT_DTA) ? RWT_DTB : RWT_DTA) :
                 rwt_state_t'(phase_q + 2'h1);
    end else if (run) begin
      case (wg)
        RWT_ONE: cnt_q <= at_top ? 12'h000 : cnt_q + 12'h001;
        RWT_TWO: begin
          cnt_q <= at_top ? 12'h000 : cnt_q + 12'h001;
          if (at_top) begin
            phase_q <= (phase_q == RWT_DTA) ? RWT_DTB : RWT_DTA;
          end
        end
        RWT_FOUR: begin
          cnt_q <= at_top ? 12'h000 : cnt_q + 12'h001;
          if (at_top) begin
            phase_q <= rwt_state_t'(phase_q + 2'h1);
          end
        end
        RWT_DUAL: begin
          if (!down_q && at_top) begin
            down_q <= 1'b1;
            cnt_q <= cnt_q - 12'h001;
          end else if (down_q && cnt_q == 12'h000) begin
            down_q <= 1'b0;
            cnt_q <= 12'h001;
          end else begin
            cnt_q <= down_q ? cnt_q - 12'h001 : cnt_q + 12'h001;
          end
        end
        default: cnt_q <= 12'h000;
      endcase
    end
  end

  // waveform units, evaluated on each counter tick
  logic wa_q, wb_q, wa_d, wb_d, cmp_hit;
  always_comb begin
    wa_d = wa_q;
    wb_d = wb_q;
    cmp_hit = 1'b0;
    case (wg)
      RWT_ONE: begin
        if (cnt_q == a_set) wa_d = 1'b1;
        if (cnt_q == a_clr && a_clr >= a_set) wa_d = 1'b0;
        if (cnt_q == b_set) wb_d = 1'b1;
        cmp_hit = cnt_q == a_set || cnt_q == a_clr || cnt_q == b_set;
      end
      RWT_TWO: begin
        if (phase_q == RWT_DTA) begin
          if (cnt_q == a_set) wa_d = 1'b1;
          if (at_top) wa_d = 1'b0;
          cmp_hit = cnt_q == a_set || at_top;
        end else if (cnt_q == b_set) begin
          wb_d = 1'b1;
          cmp_hit = 1'b1;
        end
      end
      RWT_FOUR: begin
        cmp_hit = at_top;
        if (at_top && phase_q == RWT_DTA) wa_d = 1'b1;
        if (at_top && phase_q == RWT_OTA) wa_d = 1'b0;
        if (at_top && phase_q == RWT_DTB) wb_d = 1'b1;
      end
      RWT_DUAL: begin
        if (!down_q && cnt_q == b_set) wb_d = 1'b1;
        if (down_q && cnt_q == a_set) wa_d = 1'b1;
        if (down_q && cnt_q == 12'h000) wa_d = 1'b0;
        cmp_hit = cnt_q == a_set || cnt_q == b_set;
      end
      default: ;
    endcase
    // clear compare of unit B ends everything, except in RWT_TWO phase RWT_DTA and in RWT_FOUR phases before RWT_OTB
    if (cnt_q == b_clr && !(wg == RWT_TWO && phase_q == RWT_DTA) &&
        !(wg == RWT_FOUR && phase_q != RWT_OTB)) begin
      wa_d = 1'b0;
      wb_d = 1'b0;
      cmp_hit = 1'b1;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RESET_N_I || !core_en) begin
      wa_q <= 1'b0;
      wb_q <= 1'b0;
    end else if (run) begin
      wa_q <= wa_d;
      wb_q <= wb_d;
    end
  end

  // blanking window, timed by the delay prescaler
  always_comb begin
    case (blank_sel)
      2'h1: blank_trig = cyc_end;
      2'h2: blank_trig = wrap;
      2'h3: blank_trig = run && (wa_d != wa_q || wb_d != wb_q);
      default: blank_trig = 1'b0;
    endcase
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RESET_N_I || !core_en) begin
      blank_cnt_q <= 8'h00;
    end else if (blank_trig) begin
      blank_cnt_q <= blank_len_q;
    end else if (dly_tick && blanking) begin
      blank_cnt_q <= blank_cnt_q - 8'h01;
    end
  end

  // capture from software or from an input event
  generate
    for (ge = 0; ge < 2; ge++) begin : g_cap
      always_ff @(posedge CLOCK_I) begin
        if (!RESET_N_I) begin
          cap_q[ge] <= 12'h000;
        end else if (sw_cap_q[ge] ||
                     (ev_edge[ge] && evctrl_q[ge][`RWT_EV_CAPEN])) begin
          cap_q[ge] <= cnt_q;
        end
      end
    end
  endgenerate

  // output stage
  logic wo_a_q, wo_b_q, wo_c_q, wo_d_q, cmp_ev_q, ovf_ev_q;
  wire logic wa_out = wa_q && !out_off;
  wire logic wb_out = wb_q && !out_off;
  always_ff @(posedge CLOCK_I) begin
    if (!RESET_N_I) begin
      wo_a_q <= 1'b0;
      wo_b_q <= 1'b0;
      wo_c_q <= 1'b0;
      wo_d_q <= 1'b0;
      cmp_ev_q <= 1'b0;
      ovf_ev_q <= 1'b0;
    end else begin
      wo_a_q <= wa_out;
      wo_b_q <= wb_out;
      wo_c_q <= control_second_q[`RWT_CS_MIRC] ? wb_out : wa_out;
      wo_d_q <= control_second_q[`RWT_CS_MIRD] ? wb_out : wa_out;
      cmp_ev_q <= run && cmp_hit;
      ovf_ev_q <= cyc_end;
    end
  end

  // the only path not through a flop: a fault must act without an edge
  wire logic [1:0] async_en = control_second_q[`RWT_CS_ASYNC_LO +: 2];
  wire logic async_kill = |(async_en & ev_raw);
  assign WAVE_OUT_PRIMARY_A_O = wo_a_q && !async_kill;
  assign WAVE_OUT_PRIMARY_B_O = wo_b_q && !async_kill;
  assign WAVE_OUT_MIRROR_C_O = wo_c_q && !async_kill;
  assign WAVE_OUT_MIRROR_D_O = wo_d_q && !async_kill;
  assign CMP_EVENT_O = cmp_ev_q;
  assign OVF_EVENT_O = ovf_ev_q;

  // register read, answer in the following cycle
  always_ff @(posedge CLOCK_I) begin
    if (!RESET_N_I) begin
      rdata_q <= 16'h0000;
    end else if (RD_I) begin
      case (ADDR_I)
        `RWT_CONTROL_FIRST: rdata_q <= {8'h00, control_first_q[7:1],
                                        en_req_q};
        `RWT_CONTROL_SECOND: rdata_q <= {10'h000, control_second_q};
        `RWT_DELAY_CONTROL: rdata_q <= {12'h000, delay_control_q};
        `RWT_BLANK_LEN: rdata_q <= {8'h00, blank_len_q};
        `RWT_EVCTRL_A: rdata_q <= {9'h000, evctrl_q[0]};
        `RWT_EVCTRL_B: rdata_q <= {9'h000, evctrl_q[1]};
        `RWT_A_SET: rdata_q <= {4'h0, cmp_q[0]};
        `RWT_A_CLR: rdata_q <= {4'h0, cmp_q[1]};
        `RWT_B_SET: rdata_q <= {4'h0, cmp_q[2]};
        `RWT_B_CLR: rdata_q <= {4'h0, cmp_q[3]};
        `RWT_STATUS: rdata_q <= {13'h0000, fault_q, core_en,
                                 enable_ready_flag};
        `RWT_CAPTURE_A: rdata_q <= {4'h0, cap_q[0]};
        `RWT_CAPTURE_B: rdata_q <= {4'h0, cap_q[1]};
        default: rdata_q <= 16'h0000;
      endcase
    end else begin
      rdata_q <= 16'h0000;
    end
  end
  assign RDATA_O = rdata_q;
endmodule
`default_nettype wire

// ==== core/rwt_regs.svh ====
`ifndef RWT_REGS_SVH
`define RWT_REGS_SVH

`define RWT_AW 4
`define RWT_DW 16
`define RWT_CW 12

`define RWT_CONTROL_FIRST 4'h0
`define RWT_CONTROL_SECOND 4'h1
`define RWT_DELAY_CONTROL 4'h2
`define RWT_BLANK_LEN 4'h3
`define RWT_EVCTRL_A 4'h4
`define RWT_EVCTRL_B 4'h5
`define RWT_A_SET 4'h6
`define RWT_A_CLR 4'h7
`define RWT_B_SET 4'h8
`define RWT_B_CLR 4'h9
`define RWT_STATUS 4'ha
`define RWT_COMMAND 4'hb
`define RWT_CAPTURE_A 4'hc
`define RWT_CAPTURE_B 4'hd

`define RWT_CF_EN 0
`define RWT_CF_SRC_LO 1
`define RWT_CF_SYNCP_LO 3
`define RWT_CF_CNTP_LO 5
`define RWT_CS_WG_LO 0
`define RWT_CS_MIRC 2
`define RWT_CS_MIRD 3
`define RWT_CS_ASYNC_LO 4
`define RWT_DC_DLYP_LO 0
`define RWT_DC_BLANK_LO 2
`define RWT_EV_MODE_LO 0
`define RWT_EV_FILT 4
`define RWT_EV_CAPEN 5
`define RWT_EV_INV 6
`define RWT_ST_ENABLE_READY_FLAG 0
`define RWT_ST_EN 1
`define RWT_ST_FAULT 2
`define RWT_CMD_CAPA 0
`define RWT_CMD_FCLR 2

`define RWT_FILTER_LEN 3'h3
`define RWT_NUM_MODES 4'ha

`endif

// ==== core/rwt_pkg.sv ====
`default_nettype none
package rwt_pkg;
  typedef enum logic [1:0] {
    RWT_ONE = 2'b00,
    RWT_TWO = 2'b01,
    RWT_FOUR = 2'b10,
    RWT_DUAL = 2'b11
  } rwt_wgmode_t;
  typedef enum logic [1:0] {
    RWT_DTA = 2'b00,
    RWT_OTA = 2'b01,
    RWT_DTB = 2'b10,
    RWT_OTB = 2'b11
  } rwt_state_t;
endpackage
`default_nettype wire

// ==== verif/rwt_assertions.sv ====
`include "rwt_regs.svh"
`default_nettype none
module rwt_checker
  import rwt_pkg::*;
(
  input wire logic CLOCK_I,
  input wire logic RESET_N_I,
  input wire logic [`RWT_AW-1:0] ADDR_I,
  input wire logic [`RWT_DW-1:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  input wire logic [`RWT_DW-1:0] RDATA_O,
  input wire logic [2:0] CLK_SRC_I,
  input wire logic EVENT_A_I,
  input wire logic EVENT_B_I,
  input wire logic WAVE_OUT_PRIMARY_A_O,
  input wire logic WAVE_OUT_PRIMARY_B_O,
  input wire logic WAVE_OUT_MIRROR_C_O,
  input wire logic WAVE_OUT_MIRROR_D_O,
  input wire logic CMP_EVENT_O,
  input wire logic OVF_EVENT_O
);
  logic en_q;
  logic [1:0] async_q;
  logic [3:0] idle_q;
  logic wa, wb, wc, wd, ovr;
  assign wa = WAVE_OUT_PRIMARY_A_O;
  assign wb = WAVE_OUT_PRIMARY_B_O;
  assign wc = WAVE_OUT_MIRROR_C_O;
  assign wd = WAVE_OUT_MIRROR_D_O;
  assign ovr = (async_q[0] && EVENT_A_I) || (async_q[1] && EVENT_B_I);
  // shadow of software intent; only valid while refused writes are avoided
  always_ff @(posedge CLOCK_I) begin
    if (!RESET_N_I) begin
      en_q <= 1'b0;
      async_q <= 2'b00;
    end else if (WR_I && ADDR_I == `RWT_CONTROL_FIRST) begin
      en_q <= WDATA_I[`RWT_CF_EN];
    end else if (WR_I && ADDR_I == `RWT_CONTROL_SECOND && !en_q) begin
      async_q <= WDATA_I[`RWT_CS_ASYNC_LO +: 2];
    end
  end
  // saturating count of cycles since software last dropped enable
  always_ff @(posedge CLOCK_I) begin
    if (!RESET_N_I) idle_q <= 4'hf;
    else if (en_q) idle_q <= 4'h0;
    else if (idle_q != 4'hf) idle_q <= idle_q + 4'h1;
  end
  default clocking dcb @(posedge CLOCK_I);
  endclocking
  default disable iff (!RESET_N_I);
  sequence s_all_low;
    !wa && !wb && !wc && !wd;
  endsequence
  a_rdata_idle: assert property (
    !$past(RD_I) |-> RDATA_O == 16'h0000)
    else $error("read data outside its slot");
  a_status_width: assert property (
    $past(RD_I) && $past(ADDR_I) == `RWT_STATUS |-> RDATA_O[15:3] == 13'h0)
    else $error("status unused bits set");
  a_value_width: assert property (
    $past(RD_I) && $past(ADDR_I) inside {[6:9], [12:13]}
    |-> RDATA_O[15:12] == 4'h0)
    else $error("counter value wider than twelve bits");
  a_mirror_c: assert property (!ovr |-> wc == wa || wc == wb)
    else $error("mirror c follows neither unit");
  a_mirror_d: assert property (!ovr |-> wd == wa || wd == wb)
    else $error("mirror d follows neither unit");
  a_clear_all: assert property (OVF_EVENT_O |-> ##[0:2] s_all_low)
    else $error("outputs not cleared at cycle end");
  a_async_off: assert property (async_q[0] && EVENT_A_I |-> !wa && !wb)
    else $error("override did not force outputs low");
  a_idle_quiet: assert property (
    idle_q == 4'hf |-> !CMP_EVENT_O && !OVF_EVENT_O)
    else $error("events while disabled");
  c_ovf: cover property (OVF_EVENT_O);
  c_cmp: cover property (CMP_EVENT_O);
  c_override: cover property (async_q[0] && EVENT_A_I);
endmodule
`default_nettype wire

// ==== verif/rwt_stage_model.sv ====
`default_nettype none
module rwt_stage_model (
  input wire logic clk_i,
  input wire logic hi_i,
  input wire logic lo_i,
  input wire logic trip_i,
  output logic fault_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic fault_q = 1'b0;
  // desaturation sense: shoot-through or an injected overcurrent
  always @(posedge clk_i) begin
    fault_q <= trip_i | (hi_i & lo_i);
  end
  assign fault_o = fault_q;
endmodule
`default_nettype wire

// ==== verif/rwt_top_tb.sv ====
`include "rwt_regs.svh"
`default_nettype none
module rwt_top_tb
  import rwt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [`RWT_AW-1:0] addr = 4'h0;
  logic [`RWT_DW-1:0] wdata = 16'h0000;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [`RWT_DW-1:0] rdata;
  logic [2:0] src = 3'h0;
  logic eva;
  logic evb = 1'b0;
  logic trip = 1'b0;
  logic wa, wb, wc, wd, cmp, ovf;
  logic rd_f = 1'b0;
  logic skip = 1'b1;
  logic [7:0] rnd = 8'h25;
  logic [11:0] pcnt = 12'h000;
  logic [11:0] ahi = 12'h000;
  logic [3:0] chi = 4'h0;
  logic msel = 1'b0;
  logic [11:0] cv [4];
  logic [11:0] per, hx;
  logic [16:0] rdq [$];
  logic [27:0] ovq [$];
  rwt_wgmode_t md;
  logic [15:0] cf;
  int err_count = 0;
  int compares = 0;
  int cyc = 0;
  int hi = 0;
  int mul;
  always #50 clk = ~clk;
  rwt_top rwt_top_inst (
    .CLOCK_I(clk), .RESET_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr_i), .RD_I(rd_i), .RDATA_O(rdata), .CLK_SRC_I(src),
    .EVENT_A_I(eva), .EVENT_B_I(evb), .WAVE_OUT_PRIMARY_A_O(wa),
    .WAVE_OUT_PRIMARY_B_O(wb), .WAVE_OUT_MIRROR_C_O(wc),
    .WAVE_OUT_MIRROR_D_O(wd), .CMP_EVENT_O(cmp), .OVF_EVENT_O(ovf)
  );
  rwt_stage_model rwt_stage_model_inst (
    .clk_i(clk), .hi_i(wa), .lo_i(wb), .trip_i(trip), .fault_o(eva)
  );
  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  function automatic logic [15:0] rmask(input int i);
    case (i)
      0: return 16'h00fe;
      1: return 16'h003e;
      2: return 16'h000e;
      4, 5: return 16'h007e;
      6, 7, 8, 9: return 16'h0ffe;
      10: return 16'h0001;
      default: return 16'h0000;
    endcase
  endfunction
  task automatic report_and_stop();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [27:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    wr_i <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e, input logic c);
    @(posedge clk);
    rd_i <= 1'b1;
    addr <= a;
    rdq.push_back({c, e});
    @(posedge clk);
    rd_i <= 1'b0;
    @(negedge clk);
  endtask
  // enable writes are dropped while the crossing is busy
  task automatic ready();
    for (int t = 0; t < 16; t++) begin
      rd(`RWT_STATUS, 16'h0000, 1'b0);
      if (rdata[`RWT_ST_ENABLE_READY_FLAG] === 1'b1) return;
    end
    check("enable_ready_flag", 28'h0, 28'h1);
  endtask
  always @(negedge clk) begin
    if (rd_f === 1'b1 && rdq.size() > 0) begin
      if (rdq[0][16]) check("rdata", rdata, rdq[0][15:0]);
      void'(rdq.pop_front());
    end
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    rnd <= lfsr(rnd);
    evb <= rnd[0];
    src <= cyc[3:1];
    rd_f <= rd_i;
    if (rst_n === 1'b1)
      check("mirror", 28'({wc, wd}), 28'(msel ? {wb, wb} : {wa, wa}));
    if (ovf === 1'b1) begin
      if (!skip && ovq.size() > 0)
        check("cycle", {pcnt, ahi, chi},
              ovq.pop_front());
      skip <= 1'b0;
      pcnt <= 12'h001;
      ahi <= 12'(wa);
      chi <= 4'(cmp);
    end else begin
      pcnt <= pcnt + 12'h001;
      ahi <= ahi + 12'(wa);
      chi <= chi + 4'(cmp);
    end
    if (cyc == 40000) begin
      err_count++;
      report_and_stop();
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 16; i++)
      rd(i[3:0], i == 10 ? 16'h0001 : 16'h0000, 1'b1);
    for (int i = 0; i < 15; i++) begin
      if (i inside {3, 11, 12, 13}) continue;
      wr(i[3:0], 16'hfffe);
      rd(i[3:0], rmask(i), 1'b1);
      wr(i[3:0], 16'h0000);
    end
    // modes at div 1, then div 2x4, then external source ticking every 4
    for (int k = 0; k < 6; k++) begin
      md = rwt_wgmode_t'(2'(k < 4 ? k : 0));
      cf = k == 4 ? 16'h0028 : (k == 5 ? 16'h0002 : 16'h0000);
      mul = k == 4 ? 8 : (k == 5 ? 4 : 1);
      ready();
      wr(`RWT_CONTROL_FIRST, 16'h0000);
      ready();
      wr(`RWT_CONTROL_FIRST, cf);
      msel = k[0];
      wr(`RWT_CONTROL_SECOND, {12'h0, {2{msel}}, md});
      for (int j = 0; j < 4; j++) begin
        cv[j] = (j == 0 ? 12'h0 : cv[j-1]) + 12'h1 + 12'(rnd[2*j +: 2]);
        wr(4'(6 + j), {4'h0, cv[j]});
      end
      per = md == RWT_ONE ? cv[3] + 1 : md == RWT_TWO ? cv[1] + cv[3] + 2
        : md == RWT_FOUR ? cv[0] + cv[1] + cv[2] + cv[3] + 4 : 2 * cv[3];
      hx = md == RWT_FOUR ? cv[1] + 1 : md == RWT_DUAL ? cv[0]
        : cv[1] - cv[0];
      ready();
      skip = 1'b1;
      wr(`RWT_CONTROL_FIRST, cf | 16'h0001);
      // dual slope passes both set values twice: five matches a cycle
      repeat (3) ovq.push_back({12'(per * mul), 12'(hx * mul),
                                (md == RWT_DUAL ? 4'h5 : 4'h4)});
      if (k == 0) begin
        wr(`RWT_CONTROL_SECOND, 16'h0003);
        rd(`RWT_CONTROL_SECOND, 16'h0000, 1'b1);
        rd(`RWT_STATUS, 16'h0003, 1'b1);
      end
      while (ovq.size() != 0) @(posedge clk);
    end
    ready();
    wr(`RWT_CONTROL_FIRST, 16'h0000);
    ready();
    msel = 1'b0;
    wr(`RWT_CONTROL_SECOND, 16'h0010);
    wr(`RWT_EVCTRL_A, 16'h0007);
    ready();
    wr(`RWT_CONTROL_FIRST, 16'h0001);
    repeat (20) @(posedge clk);
    trip <= 1'b1;
    repeat (2) @(posedge clk);
    trip <= 1'b0;
    repeat (6) @(posedge clk);
    rd(`RWT_STATUS, 16'h0007, 1'b1);
    for (int t = 0; t < 40; t++) begin
      @(negedge clk);
      hi += (wa === 1'b1) ? 1 : 0;
    end
    check("latched off", 24'(hi), 24'h0);
    wr(`RWT_COMMAND, 16'h0004);
    repeat (4) @(posedge clk);
    rd(`RWT_STATUS, 16'h0003, 1'b1);
    report_and_stop();
  end
endmodule
bind rwt_top rwt_checker rwt_checker_inst (
  .CLOCK_I(CLOCK_I), .RESET_N_I(RESET_N_I), .ADDR_I(ADDR_I),
  .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
  .CLK_SRC_I(CLK_SRC_I), .EVENT_A_I(EVENT_A_I), .EVENT_B_I(EVENT_B_I),
  .WAVE_OUT_PRIMARY_A_O(WAVE_OUT_PRIMARY_A_O),
  .WAVE_OUT_PRIMARY_B_O(WAVE_OUT_PRIMARY_B_O),
  .WAVE_OUT_MIRROR_C_O(WAVE_OUT_MIRROR_C_O),
  .WAVE_OUT_MIRROR_D_O(WAVE_OUT_MIRROR_D_O),
  .CMP_EVENT_O(CMP_EVENT_O), .OVF_EVENT_O(OVF_EVENT_O)
);
`default_nettype wire
